// ===== bench/blit_line_command_setup_test.sv
`timescale 1ns/1ps
`default_nettype none
module blit_line_command_setup_test;
    import blit_setup_pkg::*;
    // ---------------------------------------------------------------
    // Stimulus and observation
    // ---------------------------------------------------------------
    // Quadrant decode tables, bit q of each entry belongs to quadrant q
    localparam logic [7:0] MAJ_Y_TAB = 8'h66;
    localparam logic [7:0] X_NEG_TAB = 8'h3C;
    localparam logic [7:0] Y_NEG_TAB = 8'hF0;
    logic i_ref_clk = 1'b0;
    logic i_reset = 1'b1;
    logic [11:0] i_addr = 12'h000;
    logic [31:0] i_wdata = 32'h0000_0000;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic i_line_mode = 1'b0;
    logic [11:0] i_line_start_y = 12'h000;
    logic i_pixel_step = 1'b0;
    logic [11:0] i_clip_left = 12'h006;
    logic [11:0] i_clip_top = 12'h000;
    logic [11:0] i_clip_right = 12'h009;
    logic [11:0] i_clip_bottom = 12'h064;
    logic [15:0] i_pattern_data = 16'h1234;
    logic [15:0] i_source_data = 16'h4321;
    logic [15:0] i_dest_read_data = 16'hABCD;
    logic [31:0] o_rdata;
    logic o_busy, o_done, o_pixel_wr, o_major_y, o_x_neg, o_y_neg;
    logic [11:0] o_pixel_x, o_pixel_y;
    logic [15:0] o_pattern_value, o_compare_value;
    logic [16:0] o_error_term;
    int n_fail = 0;
    int n_checks = 0;
    blit_line_command_setup DUT (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_line_mode(i_line_mode),
        .i_line_start_y(i_line_start_y), .i_pixel_step(i_pixel_step),
        .i_clip_left(i_clip_left), .i_clip_top(i_clip_top), .i_clip_right(i_clip_right),
        .i_clip_bottom(i_clip_bottom), .i_pattern_data(i_pattern_data),
        .i_source_data(i_source_data), .i_dest_read_data(i_dest_read_data),
        .o_rdata(o_rdata), .o_busy(o_busy), .o_done(o_done), .o_pixel_wr(o_pixel_wr),
        .o_pixel_x(o_pixel_x), .o_pixel_y(o_pixel_y), .o_pattern_value(o_pattern_value),
        .o_compare_value(o_compare_value), .o_error_term(o_error_term),
        .o_major_y(o_major_y), .o_x_neg(o_x_neg), .o_y_neg(o_y_neg));
    initial begin
        forever #12.5 i_ref_clk = ~i_ref_clk;
    end
    // ---------------------------------------------------------------
    // Bus and pixel tasks
    // ---------------------------------------------------------------
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input bit ok, input string msg);
        n_checks++;
        if (!ok) begin
            $display("mismatch at %0t: %s", $time, msg);
            n_fail++;
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1;
        chk(o_rdata === exp, "read data");
    endtask
    task automatic step(input logic ew, input int ex, input int ey, input logic ed);
        @(posedge i_ref_clk);
        i_pixel_step <= 1'b1;
        @(posedge i_ref_clk);
        i_pixel_step <= 1'b0;
        #1;
        chk(o_pixel_wr === ew, "pixel write strobe");
        if (ew) begin
            chk(o_pixel_x === 12'(ex) && o_pixel_y === 12'(ey), "pixel position");
        end
        chk(o_done === ed && o_busy === !ed, "done and busy");
    endtask
    // Walks a whole window; direction signs give the expected stepping order
    task automatic run_blit(input int x0, input int y0, input int w, input int h,
                            input int dx, input int dy);
        for (int r = 0; r < h; r++) begin
            for (int c = 0; c < w; c++) begin
                step(1'b1, x0 + c * dx, y0 + r * dy, (r == h - 1) && (c == w - 1));
            end
        end
    endtask
    task automatic wait_idle();
        int k;
        k = 0;
        while (o_busy !== 1'b0 && k < 50) begin
            @(posedge i_ref_clk);
            #1;
            k++;
        end
        if (o_busy !== 1'b0) begin
            $display("mismatch at %0t: job never ended", $time);
            n_fail++;
            wrap_up();
        end
    endtask
    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (6) @(posedge i_ref_clk);
        i_reset <= 1'b0;
        rd(OFS_DRAWING_COMMAND, RESET_WORD);
        wr(OFS_DRAWING_COMMAND, 32'h0800_0000);
        chk(o_busy === 1'b0, "command write with auto execute started a job");
        rd(OFS_DRAWING_COMMAND, 32'h0800_0000);
        wr(12'h300, 32'hFFFF_FFFF);
        rd(12'h300, READ_ZERO);
        wr(OFS_SIZE_PARAMETER_WORD, 32'h0002_0003);
        rd(OFS_SIZE_PARAMETER_WORD, 32'h0002_0003);
        wr(OFS_DESTINATION_START_POSITION, 32'h0003_0005);
        chk(o_busy === 1'b1, "start write did not trigger");
        wr(OFS_SIZE_PARAMETER_WORD, 32'h0000_0000);
        rd(OFS_ENGINE_STATUS, 32'h0000_0001);
        run_blit(5, 3, 3, 2, 1, 1);
        $display("test plain window done");
        // Negative directions with corner conversion: start moves to the far corner
        wr(OFS_DRAWING_COMMAND, 32'h0800_1800);
        wr(OFS_SIZE_PARAMETER_WORD, 32'h8002_0002);
        wr(OFS_DESTINATION_START_POSITION, 32'h0003_0005);
        run_blit(6, 4, 2, 2, -1, -1);
        $display("test converted corner done");
        // Clip, solid pattern and destination compare together
        wr(OFS_PATTERN_FOREGROUND_COLOUR, 32'h0000_5A3C);
        wr(OFS_DRAWING_COMMAND, 32'hCC00_0000);
        wr(OFS_SIZE_PARAMETER_WORD, 32'h0001_0002);
        wr(OFS_DESTINATION_START_POSITION, 32'h0003_0005);
        // Pattern and compare outputs follow the latched command one cycle later
        @(posedge i_ref_clk);
        #1;
        chk(o_pattern_value === 16'h5A3C, "solid pattern");
        chk(o_compare_value === 16'hABCD, "compare source dest");
        step(1'b0, 5, 3, 1'b0);
        step(1'b1, 6, 3, 1'b1);
        // Command write without auto execute triggers directly
        wr(OFS_DRAWING_COMMAND, 32'h0000_0000);
        chk(o_busy === 1'b1, "command write did not trigger");
        @(posedge i_ref_clk);
        #1;
        chk(o_pattern_value === 16'h1234, "pattern registers");
        chk(o_compare_value === 16'h4321, "compare source");
        run_blit(5, 3, 2, 1, 1, 1);
        $display("test clip pattern compare done");
        // Line with explicit major axis and command directions, last pixel dropped
        @(posedge i_ref_clk);
        i_line_mode <= 1'b1;
        i_line_start_y <= 12'h00A;
        wr(OFS_DRAWING_COMMAND, 32'h0800_0800);
        wr(OFS_SIZE_PARAMETER_WORD, 32'hE007_FFFE);
        wr(OFS_DESTINATION_START_POSITION, 32'h0000_0014);
        chk(o_error_term === 17'h1FFFE, "error term");
        chk({o_major_y, o_x_neg, o_y_neg} === 3'b110, "explicit directions");
        step(1'b1, 20, 10, 1'b0);
        step(1'b1, 20, 11, 1'b1);
        // Quadrant decode; command direction bits set to catch a wrong source
        wr(OFS_DRAWING_COMMAND, 32'h0800_1800);
        wr(OFS_SIZE_PARAMETER_WORD, 32'h0000_0000);
        for (int q = 0; q < 8; q++) begin
            wr(OFS_DESTINATION_START_POSITION, {q[2:0], 29'h0000_0000});
            wait_idle();
            chk(o_major_y === MAJ_Y_TAB[q] && o_x_neg === X_NEG_TAB[q] &&
                o_y_neg === Y_NEG_TAB[q], "quadrant decode");
        end
        // X-major line, full length, negative X from the command bits
        wr(OFS_SIZE_PARAMETER_WORD, 32'h8004_0000);
        wr(OFS_DESTINATION_START_POSITION, 32'h0000_0014);
        step(1'b1, 20, 10, 1'b0);
        step(1'b1, 19, 10, 1'b1);
        $display("test line draw done");
        wrap_up();
    end
endmodule
`default_nettype wire

// ===== logic/blit_line_command_setup.sv
// Overview of operation
// - With command bit 26 set, pixels outside the clip rectangle are not written; clear, none are clipped.
// - Command bit 27 clear starts execution on a command write; set, on a start-position write.
// - Command bit 30 set replaces all pattern data by the pattern foreground colour.
// - Command bit 31 picks source data (0) or destination read data (1) for the colour compare.
// - Size bits 11:0 give the pixels per line loaded into the width counter.
// - Size bits 27:16 give the number of lines loaded into the height counter.
// - Size bit 31 set makes hardware turn the top-left corner into the true start from the directions.
// - Line bits 28:17 give the pixel length along the major axis.
// - Line bit 30 set drops the last pixel of the line; clear draws the full length.
// - Line bit 31 set takes the major axis from bit 29 and the directions from command bits 11 and 12.
// - Line bit 31 clear takes major axis and directions from the quadrant in start-position bits 31:29.
// - Command bit 12 clear steps lines downward with an incrementing Y position; set steps upward.
// - Quadrants 000,011 are X-major and 001,010 Y-major with positive Y; 1xx keep the major axis with both X and Y direction inverted.
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module blit_line_command_setup (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic [11:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_line_mode,
    input wire logic [blit_setup_pkg::COORD_W-1:0] i_line_start_y,
    input wire logic i_pixel_step,
    input wire logic [blit_setup_pkg::COORD_W-1:0] i_clip_left,
    input wire logic [blit_setup_pkg::COORD_W-1:0] i_clip_top,
    input wire logic [blit_setup_pkg::COORD_W-1:0] i_clip_right,
    input wire logic [blit_setup_pkg::COORD_W-1:0] i_clip_bottom,
    input wire logic [blit_setup_pkg::COLOUR_W-1:0] i_pattern_data,
    input wire logic [blit_setup_pkg::COLOUR_W-1:0] i_source_data,
    input wire logic [blit_setup_pkg::COLOUR_W-1:0] i_dest_read_data,
    output logic [31:0] o_rdata,
    output logic o_busy,
    output logic o_done,
    output logic o_pixel_wr,
    output logic [blit_setup_pkg::COORD_W-1:0] o_pixel_x,
    output logic [blit_setup_pkg::COORD_W-1:0] o_pixel_y,
    output logic [blit_setup_pkg::COLOUR_W-1:0] o_pattern_value,
    output logic [blit_setup_pkg::COLOUR_W-1:0] o_compare_value,
    output logic [blit_setup_pkg::ERR_W-1:0] o_error_term,
    output logic o_major_y,
    output logic o_x_neg,
    output logic o_y_neg
);
    import blit_setup_pkg::*;

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef enum logic [0:0] {
        IDLE = 1'b0,
        RUN = 1'b1
    } phase_type;

    typedef struct packed {
        logic [31:0] command;
        logic [31:0] size_word;
        logic [31:0] start_pos;
        logic [COLOUR_W-1:0] fg_colour;
        logic [31:0] run_command;
        logic [31:0] run_size;
        logic run_line;
        phase_type phase;
        logic [COORD_W-1:0] width_left;
        logic [COORD_W-1:0] height_left;
        logic [COORD_W-1:0] row_x;
        logic [COORD_W-1:0] cur_x;
        logic [COORD_W-1:0] cur_y;
        logic major_y;
        logic x_neg;
        logic y_neg;
        logic [31:0] rdata;
        logic done;
        logic pixel_wr;
        logic [COORD_W-1:0] pixel_x;
        logic [COORD_W-1:0] pixel_y;
        logic [COLOUR_W-1:0] pattern_value;
        logic [COLOUR_W-1:0] compare_value;
        logic [ERR_W-1:0] error_term;
    } state_type;

    state_type state;
    state_type next_state;

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    // Returns {major_y, x_neg, y_neg} for a quadrant code
    function automatic logic [2:0] quadrant_decode(input logic [2:0] quad);
        quadrant_decode = {quad[0] ^ quad[1], quad[1] ^ quad[2], quad[2]};
    endfunction

    function automatic logic [COORD_W-1:0] step_coord(input logic [COORD_W-1:0] v,
                                                      input logic neg);
        step_coord = neg ? v - ONE_COUNT : v + ONE_COUNT;
    endfunction

    function automatic logic inside_clip(input logic [COORD_W-1:0] x,
                                         input logic [COORD_W-1:0] y,
                                         input logic [COORD_W-1:0] l,
                                         input logic [COORD_W-1:0] t,
                                         input logic [COORD_W-1:0] r,
                                         input logic [COORD_W-1:0] b);
        inside_clip = (x >= l) && (x <= r) && (y >= t) && (y <= b);
    endfunction

    logic wr_command;
    logic wr_start;
    logic trigger;
    logic [31:0] trig_command;
    logic [31:0] trig_start;
    logic [2:0] quad_dirs;
    logic [COORD_W-1:0] line_len;
    logic [COORD_W-1:0] blit_w;
    logic [COORD_W-1:0] blit_h;
    logic [COORD_W-1:0] start_x;
    logic [COORD_W-1:0] start_y;
    logic step_now;
    logic last_px;

    assign wr_command = i_wr && (i_addr == OFS_DRAWING_COMMAND);
    assign wr_start = i_wr && (i_addr == OFS_DESTINATION_START_POSITION);
    // Triggers while busy are dropped so the running job keeps its parameters
    assign trigger = (state.phase == IDLE) &&
        ((wr_command && !i_wdata[CMD_AUTO_EXEC]) ||
         (wr_start && state.command[CMD_AUTO_EXEC]));
    assign trig_command = wr_command ? i_wdata : state.command;
    assign trig_start = wr_start ? i_wdata : state.start_pos;
    assign quad_dirs = quadrant_decode(trig_start[POS_QUAD_LO +: 3]);
    assign line_len = state.size_word[LN_LEN_LO +: COORD_W]
        - (state.size_word[LN_SKIP_LAST] ? ONE_COUNT : ZERO_COUNT);
    assign blit_w = state.size_word[SZ_WIDTH_LO +: COORD_W];
    assign blit_h = state.size_word[SZ_HEIGHT_LO +: COORD_W];
    assign step_now = (state.phase == RUN) && i_pixel_step;
    assign last_px = state.run_line ? (state.width_left == ONE_COUNT)
        : (state.width_left == ONE_COUNT) && (state.height_left == ONE_COUNT);

    always_comb begin
        start_x = trig_start[POS_X_LO +: COORD_W];
        start_y = i_line_mode ? i_line_start_y : trig_start[POS_Y_LO +: COORD_W];
        // Corner conversion only for block transfers
        if (!i_line_mode && state.size_word[SZ_CONVERT]) begin
            if (trig_command[CMD_X_NEG]) begin
                start_x = trig_start[POS_X_LO +: COORD_W] + blit_w - ONE_COUNT;
            end
            if (trig_command[CMD_Y_NEG]) begin
                start_y = trig_start[POS_Y_LO +: COORD_W] + blit_h - ONE_COUNT;
            end
        end
    end

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_state.done = 1'b0;
        next_state.pixel_wr = 1'b0;
        next_state.rdata = READ_ZERO;
        if (i_wr) begin
            unique case (i_addr)
                OFS_DRAWING_COMMAND: next_state.command = i_wdata;
                OFS_SIZE_PARAMETER_WORD: next_state.size_word = i_wdata;
                OFS_DESTINATION_START_POSITION: next_state.start_pos = i_wdata;
                OFS_PATTERN_FOREGROUND_COLOUR: next_state.fg_colour = i_wdata[COLOUR_W-1:0];
                default: next_state.command = state.command;
            endcase
        end
        if (i_rd) begin
            unique case (i_addr)
                OFS_DRAWING_COMMAND: next_state.rdata = state.command;
                OFS_SIZE_PARAMETER_WORD: next_state.rdata = state.size_word;
                OFS_DESTINATION_START_POSITION: next_state.rdata = state.start_pos;
                OFS_PATTERN_FOREGROUND_COLOUR: next_state.rdata = {16'h0000, state.fg_colour};
                OFS_ENGINE_STATUS: next_state.rdata = {31'h0000_0000, state.phase == RUN};
                default: next_state.rdata = READ_ZERO;
            endcase
        end
        unique case (state.phase)
            IDLE: begin
                if (trigger) begin
                    // Snapshot so later command and size writes only shape the next job
                    next_state.run_command = trig_command;
                    next_state.run_size = state.size_word;
                    next_state.run_line = i_line_mode;
                    next_state.phase = RUN;
                    next_state.cur_x = start_x;
                    next_state.cur_y = start_y;
                    next_state.row_x = start_x;
                    next_state.error_term = state.size_word[LN_ERR_LO +: ERR_W];
                    if (i_line_mode) begin
                        next_state.width_left = line_len;
                        next_state.height_left = ONE_COUNT;
                        if (state.size_word[LN_USE_CMD_DIR]) begin
                            next_state.major_y = state.size_word[LN_MAJOR_Y];
                            next_state.x_neg = trig_command[CMD_X_NEG];
                            next_state.y_neg = trig_command[CMD_Y_NEG];
                        end else begin
                            next_state.major_y = quad_dirs[2];
                            next_state.x_neg = quad_dirs[1];
                            next_state.y_neg = quad_dirs[0];
                        end
                    end else begin
                        next_state.width_left = blit_w;
                        next_state.height_left = blit_h;
                        next_state.major_y = 1'b0;
                        next_state.x_neg = trig_command[CMD_X_NEG];
                        next_state.y_neg = trig_command[CMD_Y_NEG];
                    end
                end
            end
            RUN: begin
                // Empty jobs finish at once instead of wrapping counters
                if (state.width_left == ZERO_COUNT || state.height_left == ZERO_COUNT) begin
                    next_state.phase = IDLE;
                    next_state.done = 1'b1;
                end else if (step_now) begin
                    next_state.pixel_x = state.cur_x;
                    next_state.pixel_y = state.cur_y;
                    next_state.pixel_wr = !state.run_command[CMD_CLIP_EN] ||
                        inside_clip(state.cur_x, state.cur_y, i_clip_left,
                                    i_clip_top, i_clip_right, i_clip_bottom);
                    if (last_px) begin
                        next_state.phase = IDLE;
                        next_state.done = 1'b1;
                    end else if (state.run_line) begin
                        next_state.width_left = state.width_left - ONE_COUNT;
                        if (state.major_y) begin
                            next_state.cur_y = step_coord(state.cur_y, state.y_neg);
                        end else begin
                            next_state.cur_x = step_coord(state.cur_x, state.x_neg);
                        end
                    end else if (state.width_left != ONE_COUNT) begin
                        next_state.width_left = state.width_left - ONE_COUNT;
                        next_state.cur_x = step_coord(state.cur_x, state.x_neg);
                    end else begin
                        next_state.width_left = state.run_size[SZ_WIDTH_LO +: COORD_W];
                        next_state.height_left = state.height_left - ONE_COUNT;
                        next_state.cur_x = state.row_x;
                        next_state.cur_y = step_coord(state.cur_y, state.y_neg);
                    end
                end
            end
        endcase
        next_state.pattern_value = state.run_command[CMD_SOLID_PAT]
            ? state.fg_colour : i_pattern_data;
        next_state.compare_value = state.run_command[CMD_CMP_DEST]
            ? i_dest_read_data : i_source_data;
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign o_rdata = state.rdata;
    assign o_busy = state.phase == RUN;
    assign o_done = state.done;
    assign o_pixel_wr = state.pixel_wr;
    assign o_pixel_x = state.pixel_x;
    assign o_pixel_y = state.pixel_y;
    assign o_pattern_value = state.pattern_value;
    assign o_compare_value = state.compare_value;
    assign o_error_term = state.error_term;
    assign o_major_y = state.major_y;
    assign o_x_neg = state.x_neg;
    assign o_y_neg = state.y_neg;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);

    clip_suppress_a: assert property (
        step_now && state.run_command[CMD_CLIP_EN] &&
        !inside_clip(state.cur_x, state.cur_y, i_clip_left, i_clip_top,
                     i_clip_right, i_clip_bottom) |=> !o_pixel_wr)
        else $error("clipped pixel was written");
    no_clip_write_a: assert property (
        step_now && !state.run_command[CMD_CLIP_EN] && state.width_left != ZERO_COUNT
        && state.height_left != ZERO_COUNT |=> o_pixel_wr)
        else $error("unclipped pixel not written");
    cmd_trigger_a: assert property (
        !o_busy && wr_command && !i_wdata[CMD_AUTO_EXEC] |=> o_busy)
        else $error("command write did not start");
    auto_wait_a: assert property (
        !o_busy && wr_command && i_wdata[CMD_AUTO_EXEC] && !wr_start |=> !o_busy)
        else $error("auto execute started early");
    solid_pattern_a: assert property (
        state.run_command[CMD_SOLID_PAT] && $stable(state.fg_colour)
        |=> o_pattern_value == $past(state.fg_colour))
        else $error("solid pattern not forced");
    compare_src_a: assert property (
        !state.run_command[CMD_CMP_DEST] |=> o_compare_value == $past(i_source_data))
        else $error("compare source wrong");
    width_load_a: assert property (
        trigger && !i_line_mode |=> state.width_left == $past(blit_w))
        else $error("width counter not loaded");
    height_load_a: assert property (
        trigger && !i_line_mode |=> state.height_left == $past(blit_h))
        else $error("height counter not loaded");
    corner_conv_a: assert property (
        trigger && !i_line_mode && state.size_word[SZ_CONVERT] && trig_command[CMD_X_NEG]
        |=> o_busy ##0 state.cur_x == $past(trig_start[POS_X_LO +: COORD_W] + blit_w - ONE_COUNT))
        else $error("start corner not converted");
    line_len_a: assert property (
        trigger && i_line_mode |=> state.width_left == $past(line_len))
        else $error("line length wrong");
    quad_dir_a: assert property (
        trigger && i_line_mode && !state.size_word[LN_USE_CMD_DIR]
        |=> {o_major_y, o_x_neg, o_y_neg} == $past(quad_dirs))
        else $error("quadrant directions wrong");
    cmd_dir_a: assert property (
        trigger && i_line_mode && state.size_word[LN_USE_CMD_DIR]
        |=> o_major_y == $past(state.size_word[LN_MAJOR_Y]))
        else $error("major axis bit ignored");
    latch_hold_a: assert property (
        o_busy && $past(o_busy) |-> $stable(state.run_command) && $stable(state.run_size))
        else $error("parameters changed mid job");
    row_step_a: assert property (
        step_now && !state.run_line && state.width_left == ONE_COUNT &&
        state.height_left != ONE_COUNT && state.height_left != ZERO_COUNT
        |=> state.cur_y == ($past(state.y_neg) ? $past(state.cur_y) - ONE_COUNT
                            : $past(state.cur_y) + ONE_COUNT))
        else $error("row step direction wrong");

    blit_run_c: cover property (trigger && !i_line_mode ##[1:20] o_done);
    line_run_c: cover property (trigger && i_line_mode ##[1:20] o_done);
    clipped_c: cover property (step_now && state.run_command[CMD_CLIP_EN] ##1 !o_pixel_wr);
    full_line_c: cover property (trigger && i_line_mode && !state.size_word[LN_SKIP_LAST]
        ##[1:20] o_done);
endmodule
`default_nettype wire

// ===== logic/blit_setup_pkg.sv
package blit_setup_pkg;
    // ---------------------------------------------------------------
    // Register map
    // ---------------------------------------------------------------
    localparam logic [11:0] OFS_DRAWING_COMMAND = 12'h200;
    localparam logic [11:0] OFS_SIZE_PARAMETER_WORD = 12'h204;
    localparam logic [11:0] OFS_DESTINATION_START_POSITION = 12'h208;
    localparam logic [11:0] OFS_PATTERN_FOREGROUND_COLOUR = 12'h248;
    localparam logic [11:0] OFS_ENGINE_STATUS = 12'h24C;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;
    // ---------------------------------------------------------------
    // Drawing command fields
    // ---------------------------------------------------------------
    localparam int CMD_X_NEG = 11;
    localparam int CMD_Y_NEG = 12;
    localparam int CMD_CLIP_EN = 26;
    localparam int CMD_AUTO_EXEC = 27;
    localparam int CMD_SOLID_PAT = 30;
    localparam int CMD_CMP_DEST = 31;
    // ---------------------------------------------------------------
    // Size / line parameter fields
    // ---------------------------------------------------------------
    localparam int SZ_WIDTH_LO = 0;
    localparam int SZ_HEIGHT_LO = 16;
    localparam int SZ_CONVERT = 31;
    localparam int LN_ERR_LO = 0;
    localparam int LN_LEN_LO = 17;
    localparam int LN_MAJOR_Y = 29;
    localparam int LN_SKIP_LAST = 30;
    localparam int LN_USE_CMD_DIR = 31;
    // ---------------------------------------------------------------
    // Start position fields
    // ---------------------------------------------------------------
    localparam int POS_X_LO = 0;
    localparam int POS_Y_LO = 16;
    localparam int POS_QUAD_LO = 29;
    localparam int COORD_W = 12;
    localparam int ERR_W = 17;
    localparam int COLOUR_W = 16;
    localparam logic [11:0] ONE_COUNT = 12'h001;
    localparam logic [11:0] ZERO_COUNT = 12'h000;
endpackage
